/* File: verilog/usb_phy_control_register.sv */
// Top of the USB PHY control register with AXI4-Lite access.
// Assumes a single-master AXI4-Lite bus and line state synchronous to I_CLK.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usb_phy_control_register (
  input  wire logic                                I_CLK,
  input  wire logic                                I_RST_B,
  input  wire logic [usb_phy_ctrl_pkg::ADDR_W-1:0] I_AWADDR,
  input  wire logic                                I_AWVALID,
  output logic                                     O_AWREADY,
  input  wire logic [usb_phy_ctrl_pkg::DATA_W-1:0] I_WDATA,
  input  wire logic [3:0]                          I_WSTRB,
  input  wire logic                                I_WVALID,
  output logic                                     O_WREADY,
  output logic      [1:0]                          O_BRESP,
  output logic                                     O_BVALID,
  input  wire logic                                I_BREADY,
  input  wire logic [usb_phy_ctrl_pkg::ADDR_W-1:0] I_ARADDR,
  input  wire logic                                I_ARVALID,
  output logic                                     O_ARREADY,
  output logic      [usb_phy_ctrl_pkg::DATA_W-1:0] O_RDATA,
  output logic      [1:0]                          O_RRESP,
  output logic                                     O_RVALID,
  input  wire logic                                I_RREADY,
  input  wire logic [1:0]                          I_LINE_STATE,
  input  wire logic                                I_SUSPENDED,
  output logic                                     O_PULLDOWN_DIS_PORT_EIGHT_A,
  output logic                                     O_PULLDOWN_DIS_PORT_EIGHT_B,
  output logic      [2:0]                          O_PHY_CONFIG_PINS,
  output logic                                     O_HW_RESUME,
  output logic                                     O_IRQ
);
  import usb_phy_ctrl_pkg::*;

  logic [31:0]      ctrl_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [7:0]       awaddr_reg;
  logic             aw_held_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             w_held_reg;
  logic [1:0]       filt;
  logic             filt_change;
  logic             wr_fire;
  logic [31:0]      wr_bits;
  logic [31:0]      wr_mask;
  logic             rst_wake;
  logic             k_wake;
  logic [IRQ_W-1:0] irq_set;
  logic             aw_mapped;
  logic             wr_ctrl;
  logic             wr_status;
  logic             wr_mask_sel;
  logic [31:0]      rd_word;
  logic [1:0]       rd_resp;

  ////////////////////////////////////////////////////////////////////////////
  line_state_filter u_filter (
    .i_clk      (I_CLK),
    .i_rst_b    (I_RST_B),
    .i_log2_len (ctrl_reg[DEB_MSB:DEB_LSB]),
    .i_line     (I_LINE_STATE),
    .o_filt     (filt),
    .o_change   (filt_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are captured in either order.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      O_AWREADY   <= 1'b1;
      O_WREADY    <= 1'b1;
      O_BVALID    <= 1'b0;
      O_BRESP     <= RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        awaddr_reg  <= I_AWADDR;
        aw_held_reg <= 1'b1;
        O_AWREADY   <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        wdata_reg  <= I_WDATA;
        wstrb_reg  <= I_WSTRB;
        w_held_reg <= 1'b1;
        O_WREADY   <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        O_BVALID    <= 1'b1;
        O_BRESP     <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_held_reg && w_held_reg && !O_BVALID;
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_bits = wr_mask & PHY_CTRL_WMASK;

  // Decoded write targets; the interrupt registers need a strobe on byte zero.
  assign aw_mapped   = awaddr_reg == PHY_CTRL_ADDR || awaddr_reg == IRQ_STATUS_ADDR ||
                       awaddr_reg == IRQ_MASK_ADDR || awaddr_reg == LINE_STAT_ADDR;
  assign wr_ctrl     = wr_fire && awaddr_reg == PHY_CTRL_ADDR;
  assign wr_status   = wr_fire && awaddr_reg == IRQ_STATUS_ADDR && wstrb_reg[0];
  assign wr_mask_sel = wr_fire && awaddr_reg == IRQ_MASK_ADDR && wstrb_reg[0];

  // Wake cause is taken from the filtered line state when hardware resume is on and I_SUSPENDED is high.
  // Only a settled change counts, so chatter shorter than the debounce length
  // never raises a wake flag.
  assign rst_wake = ctrl_reg[HW_RESUME_BIT] && I_SUSPENDED && filt_change && filt == LS_SE0;
  assign k_wake   = ctrl_reg[HW_RESUME_BIT] && I_SUSPENDED && filt_change && filt == LS_K;
  assign irq_set  = {filt_change, k_wake, rst_wake};

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a hardware set wins over a software clear.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_reg <= PHY_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~wr_bits) | (wdata_reg & wr_bits);
      end
      if (rst_wake) begin
        ctrl_reg[RST_WAKE_BIT] <= 1'b1;
      end
      if (k_wake) begin
        ctrl_reg[K_WAKE_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status is write-one-to-clear; set wins over clear.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
      O_IRQ          <= 1'b0;
    end else begin
      if (wr_mask_sel) begin
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      end
      if (wr_status) begin
        irq_status_reg <= (irq_status_reg & ~wdata_reg[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
      // The pin follows the status one clock later, so a clear reaches it a clock late.
      O_IRQ <= |(irq_status_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs registered from the control register.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PULLDOWN_DIS_PORT_EIGHT_A <= 1'b0;
      O_PULLDOWN_DIS_PORT_EIGHT_B <= 1'b0;
      O_PHY_CONFIG_PINS           <= 3'h0;
      O_HW_RESUME                 <= 1'b0;
    end else begin
      O_PULLDOWN_DIS_PORT_EIGHT_A <= ctrl_reg[PD_DIS_BIT];
      O_PULLDOWN_DIS_PORT_EIGHT_B <= ctrl_reg[PD_DIS_BIT];
      O_PHY_CONFIG_PINS           <= ctrl_reg[CFG_MSB:CFG_LSB];
      O_HW_RESUME                 <= ctrl_reg[HW_RESUME_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read word selected from the bus address; unmapped reads give zero.
  always_comb begin
    rd_word = 32'h0;
    rd_resp = RESP_OKAY;
    case (I_ARADDR)
      PHY_CTRL_ADDR:   rd_word = ctrl_reg & PHY_CTRL_WMASK;
      IRQ_STATUS_ADDR: rd_word = {29'h0, irq_status_reg};
      IRQ_MASK_ADDR:   rd_word = {29'h0, irq_mask_reg};
      LINE_STAT_ADDR:  rd_word = {30'h0, filt};
      default:         rd_resp = RESP_SLVERR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered the cycle after the address.
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end else begin
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID  <= 1'b1;
        O_RDATA   <= rd_word;
        O_RRESP   <= rd_resp;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID  <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/usb_phy_ctrl_pkg.sv */
// Package for the USB PHY control register block.
// Assumes a 32-bit AXI4-Lite register bus and a 200 MHz single clock.
package usb_phy_ctrl_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  PHY_CTRL_ADDR   = 8'h40;
  localparam logic [7:0]  IRQ_STATUS_ADDR = 8'h44;
  localparam logic [7:0]  IRQ_MASK_ADDR   = 8'h48;
  localparam logic [7:0]  LINE_STAT_ADDR  = 8'h4c;
  localparam int          PD_DIS_BIT      = 18;
  localparam int          RST_WAKE_BIT    = 13;
  localparam int          K_WAKE_BIT      = 12;
  localparam int          DEB_LSB         = 8;
  localparam int          DEB_MSB         = 11;
  localparam int          HW_RESUME_BIT   = 7;
  localparam int          CFG_LSB         = 4;
  localparam int          CFG_MSB         = 6;
  localparam logic [31:0] PHY_CTRL_WMASK  = 32'h0004_3ff0;
  localparam logic [31:0] PHY_CTRL_RESET  = 32'h0000_0000;
  // Line states as seen on the PHY linestate pair.
  localparam logic [1:0]  LS_SE0          = 2'h0;
  localparam logic [1:0]  LS_J            = 2'h1;
  localparam logic [1:0]  LS_K            = 2'h2;
  // Interrupt status bit positions.
  localparam int          IRQ_RST_WAKE    = 0;
  localparam int          IRQ_K_WAKE      = 1;
  localparam int          IRQ_LS_CHANGE   = 2;
  localparam int          IRQ_W           = 3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* File: verilog/line_state_filter.sv */
// Debounce filter for the two-bit PHY line state.
// Assumes line state is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module line_state_filter (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [3:0] i_log2_len,
  input  wire logic [1:0] i_line,
  output logic      [1:0] o_filt,
  output logic            o_change
);
  import usb_phy_ctrl_pkg::*;

  logic [15:0] cnt_reg;
  logic [1:0]  cand_reg;
  logic [16:0] limit;

  assign limit = 17'h1 << i_log2_len;

  // A new state must hold for 2^len clocks before it is passed on.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg  <= 16'h0;
      cand_reg <= LS_J;
      o_filt   <= LS_J;
      o_change <= 1'b0;
    end else begin
      o_change <= 1'b0;
      if (i_line != cand_reg) begin
        cand_reg <= i_line;
        cnt_reg  <= 16'h1;
        // A length of one clock passes the very first sample of a new state.
        if (i_log2_len == 4'h0 && i_line != o_filt) begin
          o_filt   <= i_line;
          o_change <= 1'b1;
        end
      end else if (cand_reg != o_filt) begin
        if ({1'b0, cnt_reg} >= limit - 17'h1) begin
          o_filt   <= cand_reg;
          o_change <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/usb_line_model.sv */
// Far side model: USB line state with bounce, and the suspend level.
// Assumes the bench steers the target state at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module usb_line_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_target,
  input  wire logic [3:0] i_bounce,
  input  wire logic       i_susp,
  output logic      [1:0] o_line = 2'h1,
  output logic            o_susp = 1'b0
);
  logic [1:0] last_reg = 2'h1;
  logic [3:0] cnt_reg  = 4'h0;
  // A new state chatters against idle J before it settles.
  always @(posedge i_clk) begin
    last_reg <= i_target;
    if (i_target != last_reg)
      cnt_reg <= i_bounce;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
    o_line <= cnt_reg[0] ? 2'h1 : last_reg;
    o_susp <= i_susp;
  end
endmodule
`default_nettype wire

/* File: verification/usb_phy_ctrl_asserts.sv */
// Checker on the ports of the USB PHY control register.
// Assumes one master that never reads while its own write is open.
`timescale 1ns/1ps
`default_nettype none
module usb_phy_ctrl_asserts import usb_phy_ctrl_pkg::*; (
  input wire logic              I_CLK,
  input wire logic              I_RST_B,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic [DATA_W-1:0] O_RDATA,
  input wire logic              O_RVALID,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic [1:0]        O_BRESP,
  input wire logic              O_PULLDOWN_DIS_PORT_EIGHT_A,
  input wire logic              O_PULLDOWN_DIS_PORT_EIGHT_B,
  input wire logic [2:0]        O_PHY_CONFIG_PINS,
  input wire logic              O_HW_RESUME
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  logic [ADDR_W-1:0] ra_reg;
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
      ra_reg <= '0;
    else if (I_ARVALID && O_ARREADY)
      ra_reg <= I_ARADDR;
  wire ctl = O_RVALID && ra_reg == PHY_CTRL_ADDR;
  wire lsr = O_RVALID && ra_reg == LINE_STAT_ADDR;
  pd_pair_a: assert property (O_PULLDOWN_DIS_PORT_EIGHT_A == O_PULLDOWN_DIS_PORT_EIGHT_B)
    else $error("pulldown pins differ");
  pd_read_a: assert property (ctl |-> O_RDATA[PD_DIS_BIT] == O_PULLDOWN_DIS_PORT_EIGHT_A)
    else $error("pulldown pin off");
  cfg_read_a: assert property (ctl |-> O_RDATA[CFG_MSB:CFG_LSB] == O_PHY_CONFIG_PINS)
    else $error("config pins off");
  resume_read_a: assert property (ctl |-> O_RDATA[HW_RESUME_BIT] == O_HW_RESUME)
    else $error("resume pin off");
  rsv_zero_a: assert property (ctl |-> (O_RDATA & ~PHY_CTRL_WMASK) == 32'h0)
    else $error("reserved bits set");
  wake_flag_a: assert property (ctl && (O_RDATA[RST_WAKE_BIT] || O_RDATA[K_WAKE_BIT]) |-> O_RDATA[HW_RESUME_BIT])
    else $error("wake flag without resume");
  line_read_a: assert property (lsr |-> O_RDATA[31:2] == 30'h0 && O_RDATA[1:0] != 2'h3)
    else $error("bad line state");
  b_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write answer dropped");
  cover property (ctl && O_RDATA[13]);
  cover property (ctl && O_RDATA[12]);
  cover property (lsr && O_RDATA[1:0] == LS_K);
endmodule
bind usb_phy_control_register usb_phy_ctrl_asserts chk_u (.*);
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the USB PHY control register.
// Assumes the design, its checker and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usb_phy_ctrl_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic rready = 1'b0, susp = 1'b0, awr, wrdy, bv, arr, rv, pd_a, pd_b, hwr, irq, so;
  logic [1:0]  tgt = 2'h1, ls, bresp, rresp;
  logic [2:0]  cfg;
  logic [3:0]  bnc = 4'h0, ws = 4'hf;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rdata, d;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          fail_count = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  usb_line_model line_u (.i_clk(clk), .i_target(tgt), .i_bounce(bnc), .i_susp(susp),
    .o_line(ls), .o_susp(so));
  usb_phy_control_register dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awa),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv),
    .O_WREADY(wrdy), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(ara),
    .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
    .I_RREADY(rready), .I_LINE_STATE(ls), .I_SUSPENDED(so), .O_HW_RESUME(hwr),
    .O_PULLDOWN_DIS_PORT_EIGHT_A(pd_a), .O_PULLDOWN_DIS_PORT_EIGHT_B(pd_b),
    .O_PHY_CONFIG_PINS(cfg), .O_IRQ(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awr);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (!wrdy);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (!bv);
    bready <= 1'b1;
    do @(posedge clk); while (!bv);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rready <= 1'b0;
  endtask
  task automatic pins(input logic [6:0] e);
    @(posedge clk);
    chk("pins", {27'h0, e}, {27'h0, pd_a, pd_b, cfg, hwr, irq});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (bv && bready)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rv && rready)
      chk("rdata", rq.pop_front(), {rresp, rdata});
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h991a));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(PHY_CTRL_ADDR, {RESP_OKAY, PHY_CTRL_RESET});
    rd(LINE_STAT_ADDR, {RESP_OKAY, 32'h1});
    pins(7'h0);
    wr(PHY_CTRL_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd(PHY_CTRL_ADDR, {RESP_OKAY, PHY_CTRL_WMASK});
    for (int i = 0; i < 8; i++) begin
      d = ($urandom & ~32'h0000_3070) | (32'(i) << CFG_LSB);
      wr(PHY_CTRL_ADDR, d, RESP_OKAY);
      rd(PHY_CTRL_ADDR, {RESP_OKAY, d & PHY_CTRL_WMASK});
      pins({d[PD_DIS_BIT], d[PD_DIS_BIT], d[CFG_MSB:CFG_LSB], d[HW_RESUME_BIT], 1'b0});
    end
    susp <= 1'b1;
    wr(PHY_CTRL_ADDR, 32'h0000_0380, RESP_OKAY);
    tgt <= LS_K;
    bnc <= 4'h5;
    rd(LINE_STAT_ADDR, {RESP_OKAY, 32'h1});
    repeat (30) @(posedge clk);
    rd(LINE_STAT_ADDR, {RESP_OKAY, 32'h2});
    rd(PHY_CTRL_ADDR, {RESP_OKAY, 32'h0000_1380});
    rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h6});
    wr(IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
    pins(7'h3);
    wr(IRQ_STATUS_ADDR, 32'h2, RESP_OKAY);
    pins(7'h2);
    wr(PHY_CTRL_ADDR, 32'h0000_0380, RESP_OKAY);
    tgt <= LS_SE0;
    bnc <= 4'h0;
    repeat (30) @(posedge clk);
    rd(PHY_CTRL_ADDR, {RESP_OKAY, 32'h0000_2380});
    rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h5});
    pins(7'h2);
    wr(IRQ_STATUS_ADDR, 32'h7, RESP_OKAY);
    wr(PHY_CTRL_ADDR, 32'h0000_0300, RESP_OKAY);
    tgt <= LS_K;
    repeat (30) @(posedge clk);
    rd(PHY_CTRL_ADDR, {RESP_OKAY, 32'h0000_0300});
    rd(IRQ_STATUS_ADDR, {RESP_OKAY, 32'h4});
    rd(8'h50, {RESP_SLVERR, 32'h0});
    wr(8'h50, 32'hffff_ffff, RESP_SLVERR);
    rd(PHY_CTRL_ADDR, {RESP_OKAY, 32'h0000_0300});
    ws <= 4'h1;
    wr(PHY_CTRL_ADDR, 32'hffff_ffff, RESP_OKAY);
    ws <= 4'hf;
    rd(PHY_CTRL_ADDR, {RESP_OKAY, 32'h0000_03f0});
    wr(IRQ_STATUS_ADDR, 32'h7, RESP_OKAY);
    wr(IRQ_MASK_ADDR, 32'h4, RESP_OKAY);
    wr(PHY_CTRL_ADDR, 32'h0000_0400, RESP_OKAY);
    tgt <= LS_J;
    repeat (9) @(posedge clk);
    pins(7'h0);
    repeat (20) @(posedge clk);
    pins(7'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
